//--- rtl/papm_pkg.sv
package papm_pkg;
  // register byte addresses on the AXI4-Lite slave
  localparam logic [3:0] PAPM_ADDR_PIN_DATA  = 4'h0;
  localparam logic [3:0] PAPM_ADDR_DIRECTION = 4'h4;
  localparam logic [3:0] PAPM_ADDR_CONFIG    = 4'h8;
  localparam logic [3:0] PAPM_ADDR_STATUS    = 4'hc;

  // pin positions inside the port
  localparam int PAPM_PIN4 = 4;
  localparam int PAPM_PIN5 = 5;
  localparam int PAPM_PIN6 = 6;
  localparam int PAPM_PIN7 = 7;

  // data bits that software may write (bits 3..0, 6, 7)
  localparam logic [7:0] PAPM_DATA_WR_MASK = 8'hcf;
  // direction bits: 1 = input; pins 4 and 5 always input
  localparam logic [7:0] PAPM_DIR_RESET    = 8'hff;
  localparam logic [7:0] PAPM_DIR_FORCED   = 8'h30;
  localparam logic [7:0] PAPM_DATA_RESET   = 8'h00;

  // config register fields
  localparam int PAPM_CFG_SMBUS_BIT = 0;
  localparam logic [1:0] AXI_RESP_OKAY   = 2'b00;
  localparam logic [1:0] AXI_RESP_SLVERR = 2'b10;
endpackage

//--- rtl/papm_port_a_upper_pad_mux.sv
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
// How it works
// - when several functions drive one pad, lowest priority number supplies the data
// - priority picks only drive data; drive enable is decided separately
// - pin 6 data: programming data, then capture/compare, then port latch
// - programming-data output on pin 6 forces the pin to output
// - otherwise pin 6 drives only when its direction bit selects output
// - pin 7 is open-drain; I2C clock out beats the port latch
// - pin 7 feeds I2C slave clock; threshold selects I2C or SMBus levels
// - pin 7 input also feeds the programming clock input
// - data bits 3..0, 6 and 7 are writable; bits 6 and 7 read the pin level, bits 3..0 read back the latch
// - data bit 4 is read-only pin level; data bits power up unknown
// - direction bit 1 releases the pin as input, 0 makes it output
module papm_port_a_upper_pad_mux
  import papm_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // pads 4..7 (oe low = driving)
  input  wire logic        port_a_pin4_in,
  input  wire logic        port_a_pin5_in,
  input  wire logic        port_a_pin6_in,
  output logic             port_a_pin6_out,
  output logic             port_a_pin6_oe_n,
  input  wire logic        port_a_pin7_in,
  output logic             port_a_pin7_out,
  output logic             port_a_pin7_oe_n,
  // peripheral side
  input  wire logic        prog_serial_data_en,
  input  wire logic        prog_serial_data_out,
  output logic             prog_serial_data_in,
  output logic             prog_serial_clock_in,
  input  wire logic        capture_compare_signal_en,
  input  wire logic        capture_compare_signal_out,
  output logic             capture_compare_signal_in,
  input  wire logic        i2c_clock_out_en,
  input  wire logic        i2c_clock_out,
  output logic             i2c_clock_in,
  output logic             i2c_smbus_levels,
  output logic             master_clear_input,
  output logic [7:0]       port_a_direction
);

  // pad input synchronisers, pins 4..7, three stages
  // the chain resets low, so pin 7 reads low for a few cycles after reset
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] sync3_q;
  logic [3:0] stable_q;
  logic [3:0] sync1_d;
  logic [3:0] sync2_d;
  logic [3:0] sync3_d;
  logic [3:0] stable_d;
  logic [3:0] pad_in;

  assign pad_in = {port_a_pin7_in, port_a_pin6_in, port_a_pin5_in, port_a_pin4_in};

  always_comb begin
    sync1_d  = pad_in;
    sync2_d  = sync1_q;
    sync3_d  = sync2_q;
    stable_d = stable_q;
    for (int i = 0; i < 4; i++) begin
      // a change counts only once stages two and three agree
      if (sync2_q[i] == sync3_q[i]) begin
        stable_d[i] = sync3_q[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q  <= 4'h0;
      sync2_q  <= 4'h0;
      sync3_q  <= 4'h0;
      stable_q <= 4'h0;
    end else begin
      sync1_q  <= sync1_d;
      sync2_q  <= sync2_d;
      sync3_q  <= sync3_d;
      stable_q <= stable_d;
    end
  end

  // register state
  logic [7:0] latch_q;
  logic [7:0] latch_d;
  logic [7:0] dir_q;
  logic [7:0] dir_d;
  logic       smbus_q;
  logic       smbus_d;
  // axi state
  logic       aw_held_q, aw_held_d;
  logic [3:0] aw_addr_q, aw_addr_d;
  logic       w_held_q, w_held_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic       bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic       rvalid_q, rvalid_d;
  logic [1:0] rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  // ready flags kept in flops so every bus output leaves a register
  logic       awready_q, awready_d;
  logic       wready_q, wready_d;
  logic       arready_q, arready_d;
  logic [7:0] pin_level;

  // pins 0..3 are outside this block; their reads follow the latch
  assign pin_level = {stable_q[3], stable_q[2], stable_q[1], stable_q[0], latch_q[3:0]};

  always_comb begin
    aw_held_d = aw_held_q;
    aw_addr_d = aw_addr_q;
    w_held_d  = w_held_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    latch_d   = latch_q;
    dir_d     = dir_q;
    smbus_d   = smbus_q;
    if (s_axi_awvalid && !aw_held_q) begin
      aw_held_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_q) begin
      w_held_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (aw_held_q && w_held_q && !bvalid_q) begin
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = AXI_RESP_OKAY;
      if (w_strb_q[0]) begin
        unique case (aw_addr_q)
          PAPM_ADDR_PIN_DATA: begin
            // bits 4 and 5 are read-only
            latch_d = (latch_q & ~PAPM_DATA_WR_MASK) | (w_data_q[7:0] & PAPM_DATA_WR_MASK);
          end
          PAPM_ADDR_DIRECTION: dir_d = w_data_q[7:0] | PAPM_DIR_FORCED;
          PAPM_ADDR_CONFIG:    smbus_d = w_data_q[PAPM_CFG_SMBUS_BIT];
          PAPM_ADDR_STATUS: ;
          default: bresp_d = AXI_RESP_SLVERR;
        endcase
      end else if (aw_addr_q[1:0] != 2'b00 || aw_addr_q > PAPM_ADDR_STATUS) begin
        bresp_d = AXI_RESP_SLVERR;
      end
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d  = AXI_RESP_OKAY;
      rdata_d  = 32'h0000_0000;
      unique case (s_axi_araddr)
        PAPM_ADDR_PIN_DATA:  rdata_d[7:0] = pin_level;
        PAPM_ADDR_DIRECTION: rdata_d[7:0] = dir_q;
        PAPM_ADDR_CONFIG:    rdata_d[PAPM_CFG_SMBUS_BIT] = smbus_q;
        PAPM_ADDR_STATUS:    rdata_d[3:0] = {prog_serial_data_en, capture_compare_signal_en,
                                             i2c_clock_out_en, port_a_pin6_oe_n};
        default:             rresp_d = AXI_RESP_SLVERR;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    // a channel is ready again once its held beat has been used
    awready_d = !aw_held_d;
    wready_d  = !w_held_d;
    arready_d = !rvalid_d;
  end

  // data latch has no reset: it powers up unknown
  always_ff @(posedge aclk) begin
    latch_q <= latch_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_held_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'b00;
      rvalid_q  <= 1'b0;
      rresp_q   <= 2'b00;
      rdata_q   <= 32'h0000_0000;
      dir_q     <= PAPM_DIR_RESET;
      smbus_q   <= 1'b0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      arready_q <= 1'b1;
    end else begin
      aw_held_q <= aw_held_d;
      aw_addr_q <= aw_addr_d;
      w_held_q  <= w_held_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
      dir_q     <= dir_d;
      smbus_q   <= smbus_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      arready_q <= arready_d;
    end
  end

  // pad drive: data by priority, enable computed on its own
  // pad controls are registered, so a request shows one cycle later
  logic p6_out_d;
  logic p6_oe_n_d;
  logic p7_out_d;
  logic p7_oe_n_d;
  logic p6_out_q;
  logic p6_oe_n_q;
  logic p7_out_q;
  logic p7_oe_n_q;

  always_comb begin
    // same-priority sources are exclusive by configuration, so no tie-break
    if (prog_serial_data_en) begin
      p6_out_d = prog_serial_data_out;
    end else if (capture_compare_signal_en) begin
      p6_out_d = capture_compare_signal_out;
    end else begin
      p6_out_d = latch_q[PAPM_PIN6];
    end
    p6_oe_n_d = prog_serial_data_en ? 1'b0 : dir_q[PAPM_PIN6];
    // pin 7 open-drain: only ever drives low
    p7_out_d  = 1'b0;
    if (i2c_clock_out_en) begin
      p7_oe_n_d = i2c_clock_out;
    end else begin
      // a latch 1 releases the pad; the pull-up gives the high level
      p7_oe_n_d = dir_q[PAPM_PIN7] | latch_q[PAPM_PIN7];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p6_out_q  <= 1'b0;
      p6_oe_n_q <= 1'b1;
      p7_out_q  <= 1'b0;
      p7_oe_n_q <= 1'b1;
    end else begin
      p6_out_q  <= p6_out_d;
      p6_oe_n_q <= p6_oe_n_d;
      p7_out_q  <= p7_out_d;
      p7_oe_n_q <= p7_oe_n_d;
    end
  end

  assign port_a_pin6_out           = p6_out_q;
  assign port_a_pin6_oe_n          = p6_oe_n_q;
  assign port_a_pin7_out           = p7_out_q;
  assign port_a_pin7_oe_n          = p7_oe_n_q;
  assign prog_serial_data_in       = stable_q[PAPM_PIN6 - 4];
  assign capture_compare_signal_in = stable_q[PAPM_PIN6 - 4];
  assign i2c_clock_in              = stable_q[PAPM_PIN7 - 4];
  assign prog_serial_clock_in      = stable_q[PAPM_PIN7 - 4];
  assign master_clear_input        = stable_q[PAPM_PIN5 - 4];
  assign i2c_smbus_levels          = smbus_q;
  assign port_a_direction          = dir_q;
  assign s_axi_awready             = awready_q;
  assign s_axi_wready              = wready_q;
  assign s_axi_bvalid              = bvalid_q;
  assign s_axi_bresp               = bresp_q;
  assign s_axi_arready             = arready_q;
  assign s_axi_rvalid              = rvalid_q;
  assign s_axi_rresp               = rresp_q;
  assign s_axi_rdata               = rdata_q;

endmodule

//--- sim/papm_board.sv
`timescale 1ns/1ps
module papm_board (
  input wire logic aclk,
  input wire logic pin6_out,
  input wire logic pin6_oe_n,
  input wire logic pin7_oe_n,
  input wire logic ext6_en,
  input wire logic ext6_val,
  input wire logic ext7_low,
  output logic     pin6,
  output logic     pin7
);
  logic last_q;
  logic last_d;
  // floating pin6 shows the inverse level so a stale read is caught
  assign last_d = pin6;
  always_ff @(posedge aclk) last_q <= last_d;
  // bus pull-up; any party pulling low wins
  assign pin7 = !(!pin7_oe_n || ext7_low);
  always_comb begin
    if (!pin6_oe_n) pin6 = pin6_out;
    else if (ext6_en) pin6 = ext6_val;
    else pin6 = !last_q;
  end
endmodule

//--- sim/papm_monitor.sv
`timescale 1ns/1ps
module papm_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic port_a_pin6_out,
  input wire logic port_a_pin6_oe_n,
  input wire logic port_a_pin7_out,
  input wire logic port_a_pin7_oe_n,
  input wire logic prog_serial_data_en,
  input wire logic prog_serial_data_out,
  input wire logic prog_serial_data_in,
  input wire logic prog_serial_clock_in,
  input wire logic capture_compare_signal_en,
  input wire logic capture_compare_signal_out,
  input wire logic capture_compare_signal_in,
  input wire logic i2c_clock_out_en,
  input wire logic i2c_clock_out,
  input wire logic i2c_clock_in,
  input wire logic [7:0] port_a_direction
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ccp_only;
    !prog_serial_data_en && capture_compare_signal_en;
  endsequence
  write_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  pin7_no_high_a: assert property (port_a_pin7_out == 1'b0)
    else $error("pin7 drives high");
  prog_wins_a: assert property (prog_serial_data_en |=> !port_a_pin6_oe_n
    && port_a_pin6_out == $past(prog_serial_data_out)) else $error("prog data lost");
  ccp_second_a: assert property (ccp_only |=> port_a_pin6_oe_n
    || port_a_pin6_out == $past(capture_compare_signal_out)) else $error("ccp data lost");
  pin6_release_a: assert property (!prog_serial_data_en && port_a_direction[6]
    |=> port_a_pin6_oe_n) else $error("pin6 drives as input");
  i2c_pull_a: assert property (i2c_clock_out_en && !i2c_clock_out |=> !port_a_pin7_oe_n)
    else $error("i2c clock not pulled");
  dir_forced_a: assert property (port_a_direction[5:4] == 2'b11)
    else $error("pins 4,5 not input");
  clk_route_a: assert property (prog_serial_clock_in == i2c_clock_in)
    else $error("pin7 routes differ");
  data_route_a: assert property (capture_compare_signal_in == prog_serial_data_in)
    else $error("pin6 routes differ");
endmodule
bind papm_port_a_upper_pad_mux papm_monitor u_mon (.*);

//--- sim/tb.sv
`timescale 1ns/1ps
module tb
  import papm_pkg::*;
;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_arready, s_axi_rvalid, port_a_pin4_in = 0, port_a_pin5_in = 0;
  logic port_a_pin6_in, port_a_pin6_out, port_a_pin6_oe_n;
  logic port_a_pin7_in, port_a_pin7_out, port_a_pin7_oe_n, master_clear_input;
  logic prog_serial_data_en = 0, prog_serial_data_out = 0, prog_serial_data_in;
  logic capture_compare_signal_en = 0, capture_compare_signal_out = 0;
  logic i2c_clock_out_en = 0, i2c_clock_out = 0, i2c_clock_in, i2c_smbus_levels;
  logic prog_serial_clock_in, capture_compare_signal_in, ext6_en = 1, ext6_val = 0;
  logic [7:0] port_a_direction;
  int n_fail = 0, samples_checked = 0;
  papm_port_a_upper_pad_mux uut (.*);
  papm_board board (.aclk, .pin6_out(port_a_pin6_out), .pin6_oe_n(port_a_pin6_oe_n),
    .pin7_oe_n(port_a_pin7_oe_n), .ext6_en, .ext6_val, .ext7_low(1'b0),
    .pin6(port_a_pin6_in), .pin7(port_a_pin7_in));
  initial forever #25 aclk = ~aclk;
  task automatic results();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic hang();
    n_fail++;
    $display("CHECK FAILED t=%0t wait ran out", $time);
    results();
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    int n;
    logic aw, w, b;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    {aw, w, b} = 3'b111;
    n = 0;
    while (b && n < 40) begin
      @(posedge aclk);
      n++;
      if (aw && s_axi_awready) begin s_axi_awvalid <= 0; aw = 0; end
      if (w && s_axi_wready) begin s_axi_wvalid <= 0; w = 0; end
      if (s_axi_bvalid) begin s_axi_bready <= 0; b = 0; chk(s_axi_bresp, AXI_RESP_OKAY); end
    end
    if (b) hang();
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid && n < 40);
    if (!s_axi_rvalid) hang();
    s_axi_rready <= 0;
    d = s_axi_rdata[7:0];
    chk(s_axi_rresp, AXI_RESP_OKAY);
  endtask
  task automatic p6(input logic pe, po, ce, co, eoe, eo);
    @(posedge aclk);
    prog_serial_data_en <= pe;
    prog_serial_data_out <= po;
    capture_compare_signal_en <= ce;
    capture_compare_signal_out <= co;
    repeat (2) @(posedge aclk);
    #1 chk(port_a_pin6_oe_n, eoe);
    if (!eoe) chk(port_a_pin6_out, eo);
  endtask
  // pad inputs pass a synchroniser, so give them time to settle
  task automatic settle();
    repeat (6) @(posedge aclk);
    #1;
  endtask
  initial begin
    logic [7:0] d;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    rd(PAPM_ADDR_DIRECTION, d);
    chk(d, PAPM_DIR_RESET);
    wr(PAPM_ADDR_CONFIG, 8'h01);
    settle();
    chk(i2c_smbus_levels, 1'b1);
    wr(PAPM_ADDR_PIN_DATA, 8'h40);
    ext6_en <= 0;
    wr(PAPM_ADDR_DIRECTION, 8'h00);
    chk(port_a_direction, 8'h30);
    p6(0, 0, 0, 0, 0, 1);
    p6(0, 0, 1, 0, 0, 0);
    p6(1, 1, 1, 0, 0, 1);
    p6(1, 0, 0, 0, 0, 0);
    chk(port_a_pin7_oe_n, 1'b0);
    wr(PAPM_ADDR_PIN_DATA, 8'hc0);
    settle();
    chk(port_a_pin7_oe_n, 1'b1);
    @(posedge aclk);
    i2c_clock_out_en <= 1;
    settle();
    chk(port_a_pin7_oe_n, 1'b0);
    chk({i2c_clock_in, prog_serial_clock_in}, 2'b00);
    @(posedge aclk);
    i2c_clock_out_en <= 0;
    settle();
    chk({i2c_clock_in, prog_serial_clock_in}, 2'b11);
    wr(PAPM_ADDR_DIRECTION, 8'hff);
    p6(1, 1, 0, 0, 0, 1);
    p6(0, 0, 1, 0, 1, 0);
    @(posedge aclk);
    ext6_en <= 1;
    port_a_pin5_in <= 1;
    settle();
    rd(PAPM_ADDR_PIN_DATA, d);
    chk(d & 8'h70, 8'h20);
    chk({master_clear_input, capture_compare_signal_in}, 2'b10);
    ext6_val <= 1;
    port_a_pin4_in <= 1;
    port_a_pin5_in <= 0;
    wr(PAPM_ADDR_PIN_DATA, 8'h25);
    settle();
    rd(PAPM_ADDR_PIN_DATA, d);
    chk(d & 8'h7f, 8'h55);
    chk(capture_compare_signal_in, 1'b1);
    results();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    hang();
  end
endmodule
